/* File: verilog/ftcls_pkg.sv */
// shared constants, types and helpers for the tag compress and lazy switch
// block; assumes one core clock and no software-visible registers
package ftcls_pkg;

	// ************************************************************
	// save image layout
	// ************************************************************
	localparam int unsigned OFS_W = 9; // byte offset width in the image
	localparam logic [8:0] TAG_OFS = 9'h004; // compressed tag byte
	localparam logic [8:0] PAD_OFS = 9'h005; // byte right after it
	localparam logic [7:0] PAD_VAL = 8'h00; // value of the pad byte
	localparam logic [1:0] TAG_EMPTY = 2'h3; // two-bit tag for empty
	localparam int unsigned NUM_REGS = 8; // data registers on the stack

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic FLAG_RST = 1'h0; // task switched flag after reset
	localparam logic [15:0] TAG_HOLD_RST = 16'hFFFF; // all registers empty

	// ************************************************************
	// types
	// ************************************************************
	// instruction classes the lazy switch trap cares about
	typedef enum logic [1:0]
	{
		INSN_OTHER,
		INSN_MEDIA128,
		INSN_MEDIA64,
		INSN_FP_STACK
	} ftcls_insn_class_t;

	// save sequencer states
	typedef enum logic [1:0]
	{
		SAVE_IDLE,
		SAVE_TAG,
		SAVE_PAD
	} ftcls_save_state_t;

	// one byte written into the save image
	typedef struct packed
	{
		logic valid;
		logic [8:0] offset;
		logic [7:0] data;
	} ftcls_save_wr_t;

	// instruction offered for issue
	typedef struct packed
	{
		logic valid;
		ftcls_insn_class_t cls;
	} ftcls_insn_t;

	// software write of the task switched flag
	typedef struct packed
	{
		logic valid;
		logic value;
	} ftcls_ts_wr_t;

	// ************************************************************
	// helpers
	// ************************************************************
	// a register holds a value unless its tag says empty
	function automatic logic ftcls_tag_present(input logic [1:0] tag);
		return tag != TAG_EMPTY;
	endfunction

	// instruction class that touches media or stack state
	function automatic logic ftcls_lazy_class(input ftcls_insn_class_t c);
		return c != INSN_OTHER;
	endfunction

endpackage

/* File: verilog/ftcls_tag_compress.sv */
// combinational squeeze of the sixteen-bit tag word into one tag byte
// assumes the caller registers the result
`timescale 1ns/1ps

module ftcls_tag_compress
(
	// full tag word, two bits per data register
	input wire logic [15:0] tag_word_i,
	// one bit per data register
	output logic [7:0] tag_byte_o
);

	// one bit per field, bit n from field n
	always_comb
	begin
		tag_byte_o = 8'h00;
		for (int n = 0; n < ftcls_pkg::NUM_REGS; n++)
		begin
			// present gives 1, empty gives 0
			tag_byte_o[n] = ftcls_pkg::ftcls_tag_present(tag_word_i[2*n +: 2]); // see R01 R02 R04
		end
	end

endmodule

/* File: verilog/ftcls_top.sv */
// top of the tag compress and lazy context switch block: writes the
// compressed tag and its pad byte into the save image, and traps media
// and stack instructions while the task switched flag is set
// assumes all inputs except reset come from logic on sys_clk_i
`timescale 1ns/1ps

// Overview of operation
// R01 - tags 00, 01, 10 saved as 1
// R02 - tag 11 saved as 0, empty
// R03 - tag stored as one byte, not word
// R04 - bit n describes data register n
// R05 - expander inspects exponent, integer bit, fraction
// R06 - expander: zero 01, normal 00, empty 11
// R07 - expander: all other values give 10
// R08 - flag set: media/stack instruction faults
// R09 - handler clears flag before returning
// R10 - legacy task switch sets the flag
// R11 - long mode: hardware never sets flag
// R12 - long mode: software sets and clears flag
// R13 - tag byte written at offset 04h
// R14 - byte at offset 05h written 00h
module ftcls_top
(
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// save request with the full tag word
	input wire logic save_req_i,
	input wire logic [15:0] tag_word_i,
	// mode and task switch events
	input wire logic long_mode_i,
	input wire logic hw_task_switch_i,
	input wire ftcls_pkg::ftcls_ts_wr_t ts_wr_i,
	// instruction offered for issue
	input wire ftcls_pkg::ftcls_insn_t insn_i,
	// save image byte writes
	output ftcls_pkg::ftcls_save_wr_t save_wr_o,
	output logic save_busy_o,
	// lazy switch trap
	output logic task_switched_flag_o,
	output logic device_unavailable_fault_o,
	output logic insn_exec_o
);

	// ************************************************************
	// reset release
	// ************************************************************
	logic rst_meta_q; // first stage, read by its own update and by the second
	logic rst_sync_q; // released reset used by the rest
	logic rst_meta_d;
	logic rst_sync_d;

	// shift a one in once reset lifts, frozen with the enable
	always_comb
	begin
		rst_meta_d = rst_meta_q | clk_en_i;
		rst_sync_d = clk_en_i ? rst_meta_q : rst_sync_q;
	end

	// only constants under reset
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta_q <= 1'h0;
			rst_sync_q <= 1'h0;
		end
		else
		begin
			rst_meta_q <= rst_meta_d;
			rst_sync_q <= rst_sync_d;
		end
	end

	// ************************************************************
	// save sequencer
	// ************************************************************
	ftcls_pkg::ftcls_save_state_t save_state_q; // sequencer state
	ftcls_pkg::ftcls_save_state_t save_state_d;
	logic [15:0] tag_hold_q; // tag word captured at the request
	logic [15:0] tag_hold_d;
	ftcls_pkg::ftcls_save_wr_t save_wr_q; // image write in flight
	ftcls_pkg::ftcls_save_wr_t save_wr_d;
	logic save_busy_q; // request would be ignored
	logic save_busy_d;
	logic [7:0] tag_byte; // compressed view of the held tag
	logic save_take; // request accepted this cycle

	// squeeze the held tag word
	ftcls_tag_compress u_compress
	(
		.tag_word_i(tag_hold_q),
		.tag_byte_o(tag_byte)
	);

	assign save_take = clk_en_i && save_req_i &&
		(save_state_q == ftcls_pkg::SAVE_IDLE);

	// tag byte first, then the pad byte, one write per cycle
	always_comb
	begin
		save_state_d = save_state_q;
		tag_hold_d = tag_hold_q;
		save_wr_d = save_wr_q;
		save_busy_d = save_busy_q;
		if (clk_en_i)
		begin
			save_wr_d.valid = 1'h0;
			case (save_state_q)
				ftcls_pkg::SAVE_IDLE:
				begin
					// requests while busy are simply ignored
					if (save_req_i)
					begin
						tag_hold_d = tag_word_i;
						save_state_d = ftcls_pkg::SAVE_TAG;
					end
				end
				ftcls_pkg::SAVE_TAG:
				begin
					// one byte holds all eight present bits
					save_wr_d.valid = 1'h1; // see R03
					save_wr_d.offset = ftcls_pkg::TAG_OFS; // see R13
					save_wr_d.data = tag_byte; // see R01 R02 R04
					save_state_d = ftcls_pkg::SAVE_PAD;
				end
				ftcls_pkg::SAVE_PAD:
				begin
					// pad byte follows the tag byte
					save_wr_d.valid = 1'h1;
					save_wr_d.offset = ftcls_pkg::PAD_OFS; // see R14
					save_wr_d.data = ftcls_pkg::PAD_VAL; // see R14
					save_state_d = ftcls_pkg::SAVE_IDLE;
				end
				default:
				begin
					// stray encoding returns to idle
					save_state_d = ftcls_pkg::SAVE_IDLE;
				end
			endcase
			save_busy_d = save_state_d != ftcls_pkg::SAVE_IDLE;
		end
	end

	// register the sequencer
	always_ff @(posedge sys_clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			save_state_q <= ftcls_pkg::SAVE_IDLE;
			tag_hold_q <= ftcls_pkg::TAG_HOLD_RST;
			save_wr_q <= '0;
			save_busy_q <= 1'h0;
		end
		else
		begin
			save_state_q <= save_state_d;
			tag_hold_q <= tag_hold_d;
			save_wr_q <= save_wr_d;
			save_busy_q <= save_busy_d;
		end
	end

	assign save_wr_o = save_wr_q;
	assign save_busy_o = save_busy_q;

	// ************************************************************
	// lazy context switch trap
	// ************************************************************
	logic flag_q; // task switched flag
	logic flag_d;
	logic fault_q; // device unavailable fault pulse
	logic fault_d;
	logic exec_q; // instruction allowed to execute
	logic exec_d;
	logic hw_set; // hardware sets the flag this cycle

	// of the task switches, only legacy mode ones set the flag
	assign hw_set = hw_task_switch_i && !long_mode_i; // see R10 R11

	// flag update and issue decision
	always_comb
	begin
		flag_d = flag_q;
		fault_d = fault_q;
		exec_d = exec_q;
		if (clk_en_i)
		begin
			// software write is the only path in long mode
			if (ts_wr_i.valid)
				flag_d = ts_wr_i.value; // see R12
			// hardware set wins over a clear in the same cycle
			if (hw_set)
				flag_d = 1'h1; // see R10
			fault_d = 1'h0;
			exec_d = 1'h0;
			if (insn_i.valid)
			begin
				// trap media and stack work while the flag is up
				if (flag_q && ftcls_pkg::ftcls_lazy_class(insn_i.cls))
				begin
					fault_d = 1'h1; // see R08
				end
				else
				begin
					exec_d = 1'h1; // see R09
				end
			end
		end
	end

	// register the trap state
	always_ff @(posedge sys_clk_i or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			flag_q <= ftcls_pkg::FLAG_RST;
			fault_q <= 1'h0;
			exec_q <= 1'h0;
		end
		else
		begin
			flag_q <= flag_d;
			fault_q <= fault_d;
			exec_q <= exec_d;
		end
	end

	assign task_switched_flag_o = flag_q;
	assign device_unavailable_fault_o = fault_q;
	assign insn_exec_o = exec_q;

	// ************************************************************
	// checks
	// ************************************************************
	logic [7:0] full_err; // present register saved as empty
	logic [7:0] empty_err; // empty register saved as present
	logic tag_wr; // tag byte on the image port

	assign tag_wr = save_wr_q.valid && (save_wr_q.offset == ftcls_pkg::TAG_OFS);

	// independent per-field comparison of the written byte
	always_comb
	begin
		for (int n = 0; n < ftcls_pkg::NUM_REGS; n++)
		begin
			empty_err[n] = save_wr_q.data[n] &&
				(tag_hold_q[2*n +: 2] == ftcls_pkg::TAG_EMPTY);
			full_err[n] = !save_wr_q.data[n] &&
				(tag_hold_q[2*n +: 2] != ftcls_pkg::TAG_EMPTY);
		end
	end

	tag_present_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R01
		save_take |-> ##2 (tag_wr && full_err == 8'h00))
		else $error("present register saved as empty");

	tag_empty_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R02
		tag_wr |-> empty_err == 8'h00)
		else $error("empty register saved as present");

	single_byte_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R03
		(tag_wr && clk_en_i) |=> !tag_wr)
		else $error("tag byte written twice");

	bit_order_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R04
		save_take |-> ##2
			(save_wr_o.data[7] == ($past(tag_word_i[15:14], 2) != 2'h3)
			&& save_wr_o.data[0] == ($past(tag_word_i[1:0], 2) != 2'h3)))
		else $error("tag bit order wrong");

	tag_offset_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R13
		(save_take ##1 clk_en_i) |=> (save_wr_o.valid && save_wr_o.offset == 9'h004))
		else $error("tag byte not at offset four");

	pad_byte_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R14
		(tag_wr && clk_en_i) |=> (save_wr_o.valid && save_wr_o.offset == 9'h005
			&& save_wr_o.data == 8'h00))
		else $error("pad byte missing or nonzero");

	fault_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R08
		(clk_en_i && insn_i.valid && flag_q && insn_i.cls != ftcls_pkg::INSN_OTHER)
		|=> (device_unavailable_fault_o && !insn_exec_o))
		else $error("trapped instruction not faulted");

	exec_pass_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R08
		(clk_en_i && insn_i.valid && !flag_q) |=> (insn_exec_o && !device_unavailable_fault_o))
		else $error("instruction faulted with flag clear");

	legacy_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R10
		(clk_en_i && hw_task_switch_i && !long_mode_i) |=> task_switched_flag_o)
		else $error("legacy task switch left flag clear");

	long_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // see R11
		(clk_en_i && long_mode_i && !ts_wr_i.valid && !flag_q) |=> !task_switched_flag_o)
		else $error("flag set by hardware in long mode");

endmodule

/* File: dv/ftcls_sw_model.sv */
// behavioural model of system software around the lazy switch trap
// assumes the bench commands explicit flag writes by one-cycle pulses
`timescale 1ns/1ps

module ftcls_sw_model
(
	// clock
	input wire logic sys_clk_i,
	// trap seen and explicit write command
	input wire logic fault_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_value_i,
	// flag write toward the device
	output ftcls_pkg::ftcls_ts_wr_t ts_wr_o
);
	// ************************************************************
	// flag writes
	// ************************************************************
	// handler clears the flag right after a trap; a command in the same cycle wins
	initial ts_wr_o = '0;
	always @(posedge sys_clk_i)
	begin
		ts_wr_o.valid <= fault_i | cmd_valid_i;
		ts_wr_o.value <= cmd_valid_i & cmd_value_i;
	end
endmodule

/* File: dv/ftcls_top_tb.sv */
// self-checking bench for the tag compress and lazy switch block
// assumes the software model in its own file drives the flag writes
`timescale 1ns/1ps

module ftcls_top_tb;
	// ************************************************************
	// signals
	// ************************************************************
	logic sys_clk = 1'b0; // core clock
	logic reset_n = 1'b0; // active low reset
	logic save_req = 1'b0; // save request
	logic [15:0] tag_word = 16'h0000; // full tag word
	logic long_mode = 1'b0; // mode select
	logic hw_ts = 1'b0; // hardware task switch pulse
	logic cmd_v = 1'b0; // model write command
	logic cmd_val = 1'b0; // model write value
	ftcls_pkg::ftcls_ts_wr_t ts_wr; // flag writes from model
	ftcls_pkg::ftcls_insn_t insn = '0; // offered instruction
	ftcls_pkg::ftcls_save_wr_t wr; // image byte writes
	logic busy, flag, fault, exec; // observed outputs
	int err_count = 0; // mismatches
	logic clk_en = 1'b1; // clock enable toward the block
	logic [7:0] last_tag; // tag byte of the latest save
	int cmp_count = 0; // comparisons
	int cyc = 0; // timeout counter

	// saved register images: sign, exponent, integer bit, fraction
	localparam logic [79:0] FPR_ZERO = {1'b0, 15'h0000, 1'b0, 63'h0};
	localparam logic [79:0] FPR_NRM = {1'b0, 15'h3FFF, 1'b1, 63'h1};
	localparam logic [79:0] FPR_INF = {1'b0, 15'h7FFF, 1'b1, 63'h0};
	localparam logic [79:0] FPR_NAN = {1'b0, 15'h7FFF, 1'b1, 63'h1};
	localparam logic [79:0] FPR_PINF = {1'b0, 15'h7FFF, 1'b0, 63'h0};
	localparam logic [79:0] FPR_UNN = {1'b0, 15'h3FFF, 1'b0, 63'h1};
	localparam logic [79:0] FPR_PDEN = {1'b0, 15'h0000, 1'b1, 63'h0};
	localparam logic [79:0] FPR_DEN = {1'b0, 15'h0000, 1'b0, 63'h1};

	always #5 sys_clk = ~sys_clk;

	ftcls_top uut
	(
		.sys_clk_i(sys_clk), .reset_n_i(reset_n), .clk_en_i(clk_en),
		.save_req_i(save_req), .tag_word_i(tag_word),
		.long_mode_i(long_mode), .hw_task_switch_i(hw_ts),
		.ts_wr_i(ts_wr), .insn_i(insn), .save_wr_o(wr),
		.save_busy_o(busy), .task_switched_flag_o(flag),
		.device_unavailable_fault_o(fault), .insn_exec_o(exec)
	);

	ftcls_sw_model sw
	(
		.sys_clk_i(sys_clk), .fault_i(fault), .cmd_valid_i(cmd_v),
		.cmd_value_i(cmd_val), .ts_wr_o(ts_wr)
	);

	// ************************************************************
	// helpers
	// ************************************************************
	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// software side: rebuild a two-bit tag from the saved register
	function automatic logic [1:0] expand_tag(input logic present,
		input logic [79:0] fpr);
		logic [14:0] ex;
		ex = fpr[78:64];
		if (!present)
			return 2'h3;
		if (ex == 15'h0000 && fpr[63:0] == 64'h0000_0000_0000_0000)
			return 2'h1;
		if (ex != 15'h0000 && ex != 15'h7FFF && fpr[63])
			return 2'h0;
		return 2'h2;
	endfunction

	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			close_out();
		end
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	// one save, tag byte at 004h then pad 00h at 005h
	task automatic save_one(input logic [15:0] tw, input logic [7:0] exp);
		@(posedge sys_clk) save_req <= 1'b1;
		tag_word <= tw;
		@(posedge sys_clk) save_req <= 1'b0;
		tag_word <= ~tw; // later changes must not leak in
		#1 chk(busy, 1'b1);
		chk(wr.valid, 1'b0);
		@(posedge sys_clk) #1 chk(wr.valid, 1'b1);
		chk(wr.offset, 9'h004);
		chk(wr.data, exp);
		last_tag = wr.data;
		@(posedge sys_clk) #1 chk(wr.valid, 1'b1);
		chk(wr.offset, 9'h005);
		chk(wr.data, 8'h00);
		chk(busy, 1'b0);
		@(posedge sys_clk) #1 chk(wr.valid, 1'b0);
	endtask

	// save, then software rebuilds the full tag word from the byte
	task automatic expand_one(input logic [15:0] tw,
		input logic [7:0] exp_byte, input logic [639:0] regs);
		logic [15:0] word;
		save_one(tw, exp_byte);
		for (int n = 0; n < 8; n++)
			word[2*n +: 2] = expand_tag(last_tag[n], regs[80*n +: 80]);
		chk(word, tw);
	endtask

	task automatic test_save();
		expand_one(16'h83F1, 8'hE3, {FPR_INF, FPR_NRM, FPR_NRM,
			FPR_NRM, FPR_NRM, FPR_NRM, FPR_NRM, FPR_ZERO});
		save_one(16'hFFFF, 8'h00);
		save_one(16'h0000, 8'hFF);
		save_one(16'h7FFD, 8'h81);
		expand_one(16'hEAAB, 8'h7E, {FPR_ZERO, FPR_INF, FPR_NAN,
			FPR_PINF, FPR_UNN, FPR_PDEN, FPR_DEN, FPR_NRM});
		$display("test save done");
	endtask

	// hardware task switch, flag expected afterwards
	task automatic hw_switch(input logic lm, input logic exp);
		@(posedge sys_clk) long_mode <= lm;
		hw_ts <= 1'b1;
		@(posedge sys_clk) hw_ts <= 1'b0;
		#1 chk(flag, exp);
	endtask

	// offer one instruction, expect trap or execution
	task automatic issue(input ftcls_pkg::ftcls_insn_class_t c,
		input logic exp_fault);
		@(posedge sys_clk) insn <= '{valid: 1'b1, cls: c};
		@(posedge sys_clk) insn <= '0;
		#1 chk(fault, exp_fault);
		chk(exec, !exp_fault);
		if (exp_fault)
		begin
			// model clears the flag, then retry runs
			@(posedge sys_clk);
			@(posedge sys_clk) #1 chk(flag, 1'b0);
			issue(c, 1'b0);
		end
	endtask

	// legacy mode: each switch arms the trap; other class runs, then one media or stack class faults
	task automatic test_legacy();
		int i;
		for (i = 1; i < 4; i++)
		begin
			hw_switch(1'b0, 1'b1);
			issue(ftcls_pkg::INSN_OTHER, 1'b0);
			issue(ftcls_pkg::ftcls_insn_class_t'(i), 1'b1);
		end
		$display("test legacy done");
	endtask

	// enable low: switch, instruction and save all leave no trace
	task automatic test_freeze();
		@(posedge sys_clk) clk_en <= 1'b0;
		long_mode <= 1'b0;
		hw_ts <= 1'b1;
		insn <= '{valid: 1'b1, cls: ftcls_pkg::INSN_FP_STACK};
		save_req <= 1'b1;
		@(posedge sys_clk) clk_en <= 1'b1;
		hw_ts <= 1'b0;
		insn <= '0;
		save_req <= 1'b0;
		#1 chk(flag, 1'b0);
		chk(fault, 1'b0);
		chk(exec, 1'b0);
		chk(busy, 1'b0);
		@(posedge sys_clk) #1 chk(flag, 1'b0);
		chk(busy, 1'b0);
		$display("test freeze done");
	endtask

	// long mode: hardware leaves the flag, software sets it
	task automatic test_long();
		hw_switch(1'b1, 1'b0);
		@(posedge sys_clk) cmd_v <= 1'b1;
		cmd_val <= 1'b1;
		@(posedge sys_clk) cmd_v <= 1'b0;
		@(posedge sys_clk) #1 chk(flag, 1'b1);
		hw_switch(1'b1, 1'b1);
		issue(ftcls_pkg::INSN_FP_STACK, 1'b1);
		$display("test long done");
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk(flag, 1'b0);
		test_save();
		test_legacy();
		test_freeze();
		test_long();
		close_out();
	end
endmodule
